//--- design/clk_ctrl_map.svh
// register offsets, field positions, reset values and main source codes of the clock control block
// assumes the including file is compiled after design/clk_ctrl_pkg.sv
//
// Functional notes
// [R1] second crystal stops only when unused by main/sub-main
// [R2] mode bit: 0 low, 1 high frequency
// [R3] aux divider codes divide by 1,2,4,8
// [R4] range field picks one of sixteen ranges
// [R5] external resistor ignores range field msb
// [R6] main source: osc, osc, second crystal, first
// [R7] main divider codes divide by 1,2,4,8
// [R8] sub-main source: osc or crystal clock
// [R9] sub-main divider codes divide by 1,2,4,8
// [R10] resistor select: internal 0, external 1
// [R11] second crystal range codes, 11 external clock
// [R12] first crystal select: source or range choice
// [R13] load capacitor codes; software keeps 00 when unused
// [R14] second crystal fault reads live fault
// [R15] first crystal fault reads live, resets one
// [R16] enable bit gates fault flag onto request
// [R17] flag reads one while interrupt pending
// [R18] software uses bit set/clear on shared registers
// [R19] flag set at reset/fault; forces osc main
// [R20] fault bits follow oscillator health automatically
// [R21] glitch-free source switch, high until new rises
// [R22] reset values 087h, 000h, 005h
// [R23] fault inputs synchronised before status use
`ifndef CLK_CTRL_MAP_SVH
`define CLK_CTRL_MAP_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define CC_ADDR_CTRL_ONE   8'h00
`define CC_ADDR_CTRL_TWO   8'h04
`define CC_ADDR_CTRL_THREE 8'h08
`define CC_ADDR_IRQ_EN     8'h0c
`define CC_ADDR_IRQ_FLAG   8'h10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CC_RST_CTRL_ONE    8'h87
`define CC_RST_CTRL_TWO    8'h00
`define CC_RST_CTRL_THREE  8'h05
`define CC_RST_IRQ_EN      8'h00
`define CC_RST_IRQ_FLAG    8'h02

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CC_C1_OSC_OFF      7
`define CC_C1_HF_MODE      6
`define CC_C1_ADIV_LO      4
`define CC_C1_RANGE_MSB    3
`define CC_C2_MSRC_LO      6
`define CC_C2_MDIV_LO      4
`define CC_C2_SSRC         3
`define CC_C2_SDIV_LO      1
`define CC_C2_RES_SEL      0
`define CC_C3_XT2R_LO      6
`define CC_C3_XT1S_LO      4
`define CC_C3_CAP_LO       2
`define CC_C3_XT2_FAULT    1
`define CC_C3_XT1_FAULT    0
`define CC_IRQ_OSC_BIT     1

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define CC_MSRC_XT2        2'h2
`define CC_MSRC_XT1        2'h3

`endif

//--- design/clk_ctrl_pkg.sv
// types shared by the clock control block
// assumes nothing of its surroundings
package clk_ctrl_pkg;

   typedef enum logic [1:0] {
      SW_RUN  = 2'b00,
      SW_WOLD = 2'b01,
      SW_WNEW = 2'b10
   } sw_state_t;

   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_RESP = 2'b01
   } ax_state_t;

endpackage

//--- design/clk_div_if.sv
// carrier between the clock control core and its clock switch
// assumes both ends run on aclk
`timescale 1ns/1ns
interface clk_div_if;
   logic       sel_new;
   logic [1:0] div_code;
   logic       src_a;
   logic       src_b;
   logic       clk_out;
   logic       switching;
   modport ctrl (output sel_new, output div_code, output src_a, output src_b,
                 input clk_out, input switching);
   modport sw   (input sel_new, input div_code, input src_a, input src_b,
                 output clk_out, output switching);
endinterface

//--- design/clk_switch.sv
// glitch-free two-source clock switch with a power-of-two divider
// assumes sources are sampled levels on aclk
`timescale 1ns/1ns
module clk_switch
   import clk_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control and clocks
   clk_div_if.sw     sw_if
);

   typedef struct packed {
      sw_state_t  st;
      logic       cur;
      logic       prev_src;
      logic [2:0] cnt;
      logic       out;
   } sw_t;

   sw_t s_r;
   sw_t s_nxt;
   logic src;
   logic rise;
   logic [2:0] lim;

   always_comb begin
      src  = s_r.cur ? sw_if.src_b : sw_if.src_a;
      rise = src & ~s_r.prev_src;
      lim  = 3'(({2'b00, 1'b1} << sw_if.div_code) - 3'h1);                 // [R3] [R7] [R9]
      s_nxt = s_r;
      s_nxt.prev_src = src;
      case (s_r.st)
         SW_RUN: begin
            if (sw_if.sel_new != s_r.cur) begin
               s_nxt.st = SW_WOLD;
            end else if (rise) begin
               if (s_r.cnt >= lim) begin
                  s_nxt.cnt = 3'h0;
                  s_nxt.out = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt + 3'h1;
               end
            end else if (!src && s_r.cnt == 3'h0) begin
               s_nxt.out = 1'b0;
            end
         end
         SW_WOLD: begin
            if (rise || s_r.out) begin                                     // [R21]
               s_nxt.out = 1'b1;
               s_nxt.st  = SW_WNEW;
               s_nxt.cur = sw_if.sel_new;
               s_nxt.prev_src = 1'b1;
            end
         end
         SW_WNEW: begin
            if (rise) begin                                                // [R21]
               s_nxt.st  = SW_RUN;
               s_nxt.cnt = 3'h0;
            end
         end
         default: s_nxt.st = SW_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sw_if.clk_out   = s_r.out;
   assign sw_if.switching = (s_r.st != SW_RUN);

   a_switch_high: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == SW_WNEW) |-> s_r.out) else $error("output fell during switch"); // [R21]

endmodule

//--- design/clk_ctrl.sv
// clock control top: registers over axi4-lite, source select, dividers, fault logic
// assumes oscillator clocks and fault inputs are asynchronous pins, sampled on aclk
`timescale 1ns/1ns
`include "clk_ctrl_map.svh"
module clk_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter bit HAS_XT2 = 1'b1
)(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // oscillator clocks
   input  wire logic        digital_osc_clk,
   input  wire logic        first_crystal_clk,
   input  wire logic        very_low_power_osc_clk,
   input  wire logic        second_crystal_clk,
   // oscillator fault pins
   input  wire logic        first_crystal_fault_in,
   input  wire logic        second_crystal_fault_in,
   // oscillator controls
   output logic             second_crystal_osc_en,
   output logic             first_crystal_hf_mode,
   output logic [3:0]       osc_range_select,
   output logic             osc_resistor_select,
   output logic [1:0]       second_crystal_range,
   output logic [1:0]       first_crystal_select,
   output logic [1:0]       crystal_load_cap,
   // clock outputs and request
   output logic             main_clk,
   output logic             sub_main_clk,
   output logic             aux_clk,
   output logic             osc_fault_irq
);

   typedef struct packed {
      ax_state_t  wst;
      ax_state_t  rst;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] c3;
      logic [7:0] ie;
      logic [7:0] ifg;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [1:0] sw;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] acnt;
      logic       aclk_q;
      logic       aux_prev;
      logic       osc_en;
      logic       irq;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   clk_div_if m_if ();
   clk_div_if sm_if ();

   logic xt1_fault;
   logic xt2_fault;
   logic dco_s;
   logic lf_s;
   logic xt2_s;
   logic alt_s;
   logic [7:0] c3_rd;
   logic [7:0] wbyte;
   logic       m_uses_xt2;
   logic       s_uses_xt2;
   logic       aux_src;
   logic [2:0] alim;

   // ------------------------------------------------------------
   // synchronisers, two stages each
   // ------------------------------------------------------------
   assign xt1_fault = s_r.s2[0];                                           // [R23]
   assign xt2_fault = s_r.s2[1] & s_r.osc_en;                              // [R20]
   assign dco_s = s_r.s2[2];
   assign lf_s  = s_r.s2[3];
   assign xt2_s = s_r.sw[1];
   assign alt_s = HAS_XT2 ? xt2_s : lf_s;

   // ------------------------------------------------------------
   // clock switches
   // ------------------------------------------------------------
   always_comb begin
      m_uses_xt2 = HAS_XT2 & (s_r.c2[`CC_C2_MSRC_LO +: 2] == `CC_MSRC_XT2)
                   & ~s_r.ifg[`CC_IRQ_OSC_BIT];
      s_uses_xt2 = HAS_XT2 & s_r.c2[`CC_C2_SSRC];
      // [R19] flag forces main clock onto the oscillator
      m_if.sel_new  = s_r.c2[`CC_C2_MSRC_LO+1] & ~s_r.ifg[`CC_IRQ_OSC_BIT]; // [R6] [R19]
      m_if.div_code = s_r.c2[`CC_C2_MDIV_LO +: 2];                        // [R7]
      m_if.src_a    = dco_s;
      m_if.src_b    = (s_r.c2[`CC_C2_MSRC_LO +: 2] == `CC_MSRC_XT2) ? alt_s : lf_s;
      sm_if.sel_new  = s_uses_xt2;                                         // [R8]
      sm_if.div_code = s_r.c2[`CC_C2_SDIV_LO +: 2];                        // [R9]
      sm_if.src_a    = dco_s;
      sm_if.src_b    = alt_s;
   end

   clk_switch u_main (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sw_if   (m_if)
   );

   clk_switch u_sub (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sw_if   (sm_if)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      c3_rd = {s_r.c3[7:2], xt2_fault, xt1_fault};                         // [R14] [R15]
      wbyte = s_axi_wdata[7:0];
      s_nxt.s1 = {first_crystal_clk | very_low_power_osc_clk & 1'b0, digital_osc_clk,
                  second_crystal_fault_in, first_crystal_fault_in};
      s_nxt.s2 = s_r.s1;
      s_nxt.sw = {s_r.sw[0], second_crystal_clk};
      // [R1] second crystal stays on while a clock uses it
      s_nxt.osc_en = ~s_r.c1[`CC_C1_OSC_OFF] | m_uses_xt2 | s_uses_xt2;    // [R1]
      // aux divider on the first crystal path
      aux_src = lf_s;
      alim = 3'(({2'b00, 1'b1} << s_r.c1[`CC_C1_ADIV_LO +: 2]) - 3'h1);   // [R3]
      s_nxt.aux_prev = aux_src;
      if (aux_src && !s_r.aux_prev) begin
         if (s_r.acnt >= alim) begin
            s_nxt.acnt = 3'h0;
            s_nxt.aclk_q = 1'b1;
         end else begin
            s_nxt.acnt = s_r.acnt + 3'h1;
         end
      end else if (!aux_src && s_r.acnt == 3'h0) begin
         s_nxt.aclk_q = 1'b0;
      end
      // write channel: address and data taken together
      s_nxt.bresp = 2'b00;
      if (s_r.wst == AX_IDLE && s_axi_awvalid && s_axi_wvalid) begin
         s_nxt.wst = AX_RESP;
         if (s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
               `CC_ADDR_CTRL_ONE:   s_nxt.c1 = wbyte;                      // [R2] [R4]
               `CC_ADDR_CTRL_TWO:   s_nxt.c2 = wbyte;                      // [R10]
               `CC_ADDR_CTRL_THREE: s_nxt.c3 = {wbyte[7:2], 2'b00};        // [R11] [R12] [R13]
               `CC_ADDR_IRQ_EN:     s_nxt.ie = wbyte;                      // [R16]
               `CC_ADDR_IRQ_FLAG:   s_nxt.ifg = wbyte;                     // [R17]
               default:             s_nxt.bresp = 2'b10;
            endcase
         end
         s_nxt.bresp = (s_axi_awaddr > `CC_ADDR_IRQ_FLAG || s_axi_awaddr[1:0] != 2'b00)
                       ? 2'b10 : 2'b00;
      end else if (s_r.wst == AX_RESP) begin
         s_nxt.bresp = s_r.bresp;
         if (s_axi_bready) begin
            s_nxt.wst = AX_IDLE;
         end
      end
      // fault sets the flag and wins over a software clear
      if (xt1_fault || xt2_fault) begin
         s_nxt.ifg[`CC_IRQ_OSC_BIT] = 1'b1;                                // [R19]
      end
      // read channel
      if (s_r.rst == AX_IDLE && s_axi_arvalid) begin
         s_nxt.rst = AX_RESP;
         s_nxt.rresp = 2'b00;
         case (s_axi_araddr)
            `CC_ADDR_CTRL_ONE:   s_nxt.rdata = {24'h0, s_r.c1};
            `CC_ADDR_CTRL_TWO:   s_nxt.rdata = {24'h0, s_r.c2};
            `CC_ADDR_CTRL_THREE: s_nxt.rdata = {24'h0, c3_rd};
            `CC_ADDR_IRQ_EN:     s_nxt.rdata = {24'h0, s_r.ie};
            `CC_ADDR_IRQ_FLAG:   s_nxt.rdata = {24'h0, s_r.ifg};
            default: begin
               s_nxt.rdata = 32'h0;
               s_nxt.rresp = 2'b10;
            end
         endcase
      end else if (s_r.rst == AX_RESP && s_axi_rready) begin
         s_nxt.rst = AX_IDLE;
      end
      s_nxt.irq = s_r.ifg[`CC_IRQ_OSC_BIT] & s_r.ie[`CC_IRQ_OSC_BIT];      // [R16]
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r       <= '0;
         s_r.c1    <= `CC_RST_CTRL_ONE;                                    // [R22]
         s_r.c2    <= `CC_RST_CTRL_TWO;
         s_r.c3    <= `CC_RST_CTRL_THREE;
         s_r.ie    <= `CC_RST_IRQ_EN;
         s_r.ifg   <= `CC_RST_IRQ_FLAG;                                    // [R19]
         s_r.s2    <= 4'h1;                                                // [R15]
         s_r.s1    <= 4'h1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = (s_r.wst == AX_IDLE) & s_axi_awvalid & s_axi_wvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_bvalid  = (s_r.wst == AX_RESP);
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = (s_r.rst == AX_IDLE) & s_axi_arvalid;
   assign s_axi_rvalid  = (s_r.rst == AX_RESP);
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign second_crystal_osc_en = s_r.osc_en;
   assign first_crystal_hf_mode = s_r.c1[`CC_C1_HF_MODE];                  // [R2]
   // [R5] msb masked when external resistor selected
   assign osc_range_select = {s_r.c1[`CC_C1_RANGE_MSB] & ~s_r.c2[`CC_C2_RES_SEL],
                              s_r.c1[2:0]};                                // [R5]
   assign osc_resistor_select  = s_r.c2[`CC_C2_RES_SEL];                   // [R10]
   assign second_crystal_range = s_r.c3[`CC_C3_XT2R_LO +: 2];              // [R11]
   assign first_crystal_select = s_r.c3[`CC_C3_XT1S_LO +: 2];              // [R12]
   assign crystal_load_cap     = s_r.c3[`CC_C3_CAP_LO +: 2];               // [R13]
   assign main_clk      = m_if.clk_out;
   assign sub_main_clk  = sm_if.clk_out;
   assign aux_clk       = s_r.aclk_q;
   assign osc_fault_irq = s_r.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_xt2_stays_on: assert property (@(posedge aclk) disable iff (!aresetn)
      (m_uses_xt2 || s_uses_xt2) |=> s_r.osc_en) else $error("crystal off while used"); // [R1]
   a_range_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.c2[0] |-> !osc_range_select[3]) else $error("range msb not masked"); // [R5]
   a_fault_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (xt1_fault || xt2_fault) |=> s_r.ifg[1]) else $error("fault flag not set"); // [R19]
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_r.ie[1] |=> !osc_fault_irq) else $error("request while disabled"); // [R16]
   a_flag_forces_osc: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.ifg[1] |-> !m_if.sel_new) else $error("main not on oscillator"); // [R19]
   a_fault_sync: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.s2[0]) |-> $past(first_crystal_fault_in, 2)) else $error("fault not synced"); // [R23]
   a_status_live: assert property (@(posedge aclk) disable iff (!aresetn)
      c3_rd[0] == s_r.s2[0]) else $error("status bit stale"); // [R15]
   a_hf_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      first_crystal_hf_mode == s_r.c1[6]) else $error("mode bit wrong"); // [R2]

endmodule

//--- testbench/osc_model.sv
// oscillator model: four free-running clocks and two fault pins
// assumes the bench commands faults; the second crystal rests low while disabled
`timescale 1ns/1ns
module osc_model (
   // control
   input  wire logic       xt2_en,
   input  wire logic [1:0] fault_cmd,
   // clocks and faults
   output logic            dosc,
   output logic            xt1,
   output logic            very_low_power_osc,
   output logic            xt2,
   output logic [1:0]      fault
);
   // ------------------------------------------------------------
   // clocks, unrelated in phase to aclk
   // ------------------------------------------------------------
   initial begin
      dosc = 1'b0;
      xt1  = 1'b0;
      very_low_power_osc  = 1'b0;
      xt2  = 1'b0;
   end
   always #20 dosc = ~dosc;
   always #52 xt1 = ~xt1;
   always #76 very_low_power_osc = ~very_low_power_osc;
   always #28 xt2 = ~xt2 & xt2_en;
   // a stopped crystal cannot report a fault
   assign fault = {fault_cmd[1] & xt2_en, fault_cmd[0]};
endmodule

//--- testbench/clk_ctrl_tb.sv
// self-checking bench for the clock control block
// assumes the oscillator model drives the clock and fault pins
`timescale 1ns/1ns
`include "clk_ctrl_map.svh"
module clk_ctrl_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, arready, bvalid, rvalid, irq, xt2_en, hf, res;
   logic        mclk, sclk, aux, dosc, xt1, very_low_power_osc, xt2;
   logic [7:0]  awaddr, araddr, c1, c2, c3;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, rng;
   logic [1:0]  bresp, rresp, xr, xs, cap, fault, fcmd;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          err_total, check_count, seed;
   wire  [2:0]  outs = {aux, sclk, mclk};
   wire  [3:0]  srcs = {xt2, very_low_power_osc, xt1, dosc};

   osc_model i_osc (.xt2_en(xt2_en), .fault_cmd(fcmd), .dosc(dosc), .xt1(xt1), .very_low_power_osc(very_low_power_osc),
                    .xt2(xt2), .fault(fault));
   clk_ctrl #(.HAS_XT2(1'b1)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .digital_osc_clk(dosc), .first_crystal_clk(xt1), .very_low_power_osc_clk(very_low_power_osc),
      .second_crystal_clk(xt2), .first_crystal_fault_in(fault[0]),
      .second_crystal_fault_in(fault[1]), .second_crystal_osc_en(xt2_en),
      .first_crystal_hf_mode(hf), .osc_range_select(rng), .osc_resistor_select(res),
      .second_crystal_range(xr), .first_crystal_select(xs), .crystal_load_cap(cap),
      .main_clk(mclk), .sub_main_clk(sclk), .aux_clk(aux), .osc_fault_irq(irq));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // compare, verdict and response monitor
   // ------------------------------------------------------------
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(negedge aclk) begin
      if (bvalid && bready && bq.size() > 0) check({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
   end

   // ------------------------------------------------------------
   // axi4-lite master
   // ------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [33:0] e);
      int   n;
      logic pa, pw, pq, pr, ta, tw, tq, tr;
      @(posedge aclk);
      if (wr) bq.push_back(e[33:32]);
      else rq.push_back(e);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      wstrb <= s;
      pa = wr;
      pw = wr;
      pq = !wr;
      pr = 1'b1;
      awvalid <= pa;
      wvalid <= pw;
      arvalid <= pq;
      bready <= wr;
      rready <= !wr;
      n = 0;
      while (pr && n < 200) begin
         @(negedge aclk);
         n++;
         ta = pa && awready;
         tw = pw && wready;
         tq = pq && arready;
         tr = wr ? bvalid : rvalid;
         @(posedge aclk);
         pa = pa & ~ta;
         pw = pw & ~tw;
         pq = pq & ~tq;
         pr = ~tr;
         awvalid <= pa;
         wvalid <= pw;
         arvalid <= pq;
         bready <= pr & wr;
         rready <= pr & ~wr;
      end
      if (pr) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      r = $random(seed);
      bus(1'b1, a, {r[31:8], d}, 4'h1, 34'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      bus(1'b0, a, 32'h0, 4'h0, {26'h0, d});
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // counts output edges against source edges over a fixed window
   task automatic rate(input int ch, input int src, input int dv);
      int   oc, sc;
      logic po, ps;
      tick(64);
      oc = 0;
      sc = 0;
      po = outs[ch];
      ps = srcs[src];
      repeat (480) begin
         @(negedge aclk);
         oc += int'(outs[ch] && !po);
         sc += int'(srcs[src] && !ps);
         po = outs[ch];
         ps = srcs[src];
      end
      sc = sc >> dv;
      check(34'((oc - sc <= 1 && sc - oc <= 1) ? sc : oc), 34'(sc));
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      fcmd = 2'b01;
      err_total = 0;
      check_count = 0;
      seed = 32'hc8c5f67b;
      tick(20);
      aresetn <= 1'b1;
      tick(8);
      rd(`CC_ADDR_CTRL_ONE, 8'h87);
      rd(`CC_ADDR_CTRL_TWO, 8'h00);
      rd(`CC_ADDR_CTRL_THREE, 8'h05);
      rd(`CC_ADDR_IRQ_EN, 8'h00);
      rd(`CC_ADDR_IRQ_FLAG, 8'h02);
      check(34'(irq), 34'h0);
      wr(`CC_ADDR_IRQ_FLAG, 8'h00);
      rd(`CC_ADDR_IRQ_FLAG, 8'h02);
      fcmd <= 2'b00;
      tick(8);
      rd(`CC_ADDR_CTRL_THREE, 8'h04);
      wr(`CC_ADDR_IRQ_FLAG, 8'h00);
      rd(`CC_ADDR_IRQ_FLAG, 8'h00);
      wr(`CC_ADDR_IRQ_EN, 8'h02);
      tick(2);
      check(34'(irq), 34'h0);
      wr(`CC_ADDR_CTRL_ONE, 8'h07);
      tick(4);
      check(34'(xt2_en), 34'h1);
      fcmd <= 2'b10;
      tick(8);
      rd(`CC_ADDR_CTRL_THREE, 8'h06);
      rd(`CC_ADDR_IRQ_FLAG, 8'h02);
      check(34'(irq), 34'h1);
      fcmd <= 2'b00;
      tick(8);
      wr(`CC_ADDR_CTRL_ONE, 8'h87);
      wr(`CC_ADDR_IRQ_EN, 8'h00);
      tick(2);
      check(34'(irq), 34'h0);
      wr(`CC_ADDR_IRQ_FLAG, 8'h00);
      rd(`CC_ADDR_IRQ_FLAG, 8'h00);
      bus(1'b1, 8'h14, 32'hff, 4'h1, {2'b10, 32'h0});
      bus(1'b0, 8'h14, 32'h0, 4'h0, {2'b10, 32'h0});
      bus(1'b0, 8'h02, 32'h0, 4'h0, {2'b10, 32'h0});
      bus(1'b1, `CC_ADDR_CTRL_ONE, 32'h0, 4'h0, 34'h0);
      rd(`CC_ADDR_CTRL_ONE, 8'h87);
      for (int i = 0; i < 10; i++) begin
         c1 = $random(seed);
         c2 = $random(seed);
         c3 = $random(seed);
         if (i < 3) c1[7] = 1'b1;
         if (i < 3) c2 = (i == 0) ? 8'h80 : (i == 1) ? 8'h08 : 8'h00;
         c3[1:0] = 2'b00;
         if (c1[6] || c3[5:4] == 2'b11) c3[3:2] = 2'b00;
         wr(`CC_ADDR_CTRL_ONE, c1);
         wr(`CC_ADDR_CTRL_TWO, c2);
         wr(`CC_ADDR_CTRL_THREE, c3);
         rd(`CC_ADDR_CTRL_ONE, c1);
         rd(`CC_ADDR_CTRL_TWO, c2);
         rd(`CC_ADDR_CTRL_THREE, c3);
         check(34'(xt2_en), 34'(!c1[7] || c2[7:6] == 2'b10 || c2[3]));
         check(34'({hf, res, xr, xs, cap}), 34'({c1[6], c2[0], c3[7:2]}));
         check(34'(rng), 34'({c1[3] & ~c2[0], c1[2:0]}));
      end
      wr(`CC_ADDR_CTRL_THREE, 8'h00);
      for (int dv = 0; dv < 4; dv++) begin
         wr(`CC_ADDR_CTRL_ONE, {2'b00, 2'(dv), 4'h7});
         wr(`CC_ADDR_CTRL_TWO, {2'b00, 2'(dv), 1'b0, 2'(dv), 1'b0});
         rate(0, 0, dv);
         rate(1, 0, dv);
         rate(2, 1, dv);
      end
      wr(`CC_ADDR_CTRL_TWO, 8'h88);
      rate(0, 3, 0);
      rate(1, 3, 0);
      wr(`CC_ADDR_CTRL_TWO, 8'h40);
      rate(0, 0, 0);
      wr(`CC_ADDR_CTRL_TWO, 8'hc0);
      rate(0, 1, 0);
      fcmd <= 2'b01;
      tick(8);
      rd(`CC_ADDR_IRQ_FLAG, 8'h02);
      rate(0, 0, 0);
      fcmd <= 2'b00;
      aresetn <= 1'b0;
      tick(2);
      aresetn <= 1'b1;
      tick(4);
      rd(`CC_ADDR_CTRL_ONE, 8'h87);
      rd(`CC_ADDR_CTRL_TWO, 8'h00);
      rd(`CC_ADDR_IRQ_FLAG, 8'h02);
      stop_test();
   end
endmodule
